// File: design/iafu_pkg.sv
// Package for the integer add and flag unit: opcodes, fields, register map
// Overview of operation
// - Operands from registers or immediates only
// - Operands are signed two's-complement
// - Flags derive from the written result
// - Carry flag is carry out of MSB
// - Overflow tracks signed overflow, sets summary
// - Adds never clear summary overflow flag
// - Overflow flags change only when enabled
// - Record bit writes condition field zero, except for ADDI and ADDIS
// - Flag writers stall following issue
// - Immediates sign-extended before the adder
// - Register sum; carrying forms update carry
// - Immediate sum uses zero for register zero
// - Shifted immediate sum updates no flags
// - Extended sum adds carry, updates carry
// - Minus-one sum adds carry and ones
// - Zero-extended sum adds carry, updates carry
// - Carry chaining allows wide sums
package iafu_pkg;

    // Addition forms selected by the issue logic
    typedef enum logic [2:0] {
        IAFU_OP_ADD    = 3'h0,
        IAFU_OP_ADDC   = 3'h1,
        IAFU_OP_ADDI   = 3'h2,
        IAFU_OP_ADDIC  = 3'h3,
        IAFU_OP_ADDIS  = 3'h4,
        IAFU_OP_ADDE   = 3'h5,
        IAFU_OP_ADDME  = 3'h6,
        IAFU_OP_ADDZE  = 3'h7
    } iafu_op_t;

    // Execution state, one-hot
    typedef enum logic [1:0] {
        IAFU_ST_IDLE = 2'b01,
        IAFU_ST_WAIT = 2'b10
    } iafu_state_t;

    localparam int unsigned IAFU_XLEN      = 32;
    localparam int unsigned IAFU_IMM_W     = 16;
    localparam int unsigned IAFU_REG_AW    = 5;
    localparam int unsigned IAFU_NUM_REGS  = 32;

    // Condition field zero bit positions (big-endian 0:3 map to 3..0)
    localparam int unsigned IAFU_CF_LT     = 3;
    localparam int unsigned IAFU_CF_GT     = 2;
    localparam int unsigned IAFU_CF_EQ     = 1;
    localparam int unsigned IAFU_CF_SO     = 0;

    // Exception register: summary, overflow, carry in top three bits
    localparam int unsigned IAFU_XR_SO     = 31;
    localparam int unsigned IAFU_XR_OVF    = 30;
    localparam int unsigned IAFU_XR_CRY    = 29;

    localparam logic [31:0] IAFU_ALL_ONES  = 32'hFFFF_FFFF;
    localparam logic [31:0] IAFU_ZERO      = 32'h0000_0000;
    localparam logic [3:0]  IAFU_CF_RESET  = 4'h0;

    // AXI4-Lite register byte offsets
    localparam logic [7:0] IAFU_A_CTRL     = 8'h00;
    localparam logic [7:0] IAFU_A_EXC      = 8'h04;
    localparam logic [7:0] IAFU_A_COND     = 8'h08;
    localparam logic [7:0] IAFU_A_IRQ_ST   = 8'h0C;
    localparam logic [7:0] IAFU_A_IRQ_MSK  = 8'h10;
    localparam logic [7:0] IAFU_A_REG_SEL  = 8'h14;
    localparam logic [7:0] IAFU_A_REG_DAT  = 8'h18;

    // Interrupt status bits: overflow set, carry set, summary set
    localparam int unsigned IAFU_IRQ_W     = 3;
    localparam int unsigned IAFU_IRQ_OVF   = 0;
    localparam int unsigned IAFU_IRQ_CRY   = 1;
    localparam int unsigned IAFU_IRQ_SO    = 2;

    localparam logic [1:0] IAFU_RESP_OKAY   = 2'b00;
    localparam logic [1:0] IAFU_RESP_SLVERR = 2'b10;

endpackage

// File: design/iafu_top.sv
// Integer add and flag unit with register file and AXI4-Lite slave
`timescale 1ns/1ps
module iafu_top
    import iafu_pkg::*;
#(
    parameter int unsigned XLEN = IAFU_XLEN
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Issue port
    input  wire logic              issue_valid,
    input  wire iafu_op_t          issue_op,
    input  wire logic [4:0]        dest_reg,
    input  wire logic [4:0]        first_source_reg,
    input  wire logic [4:0]        second_source_reg,
    input  wire logic [15:0]       signed_immediate,
    input  wire logic              overflow_enable,
    input  wire logic              record_bit,
    output logic                   issue_ready,
    output logic                   done,
    output logic [XLEN-1:0]        result,
    output logic                   irq,
    // AXI4-Lite slave
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    // Architectural state
    logic [XLEN-1:0]     general_register [IAFU_NUM_REGS];
    logic                carry_flag_q;
    logic                overflow_flag_q;
    logic                summary_flag_q;
    logic [3:0]          condition_field_zero_q;
    iafu_state_t         state_q;
    logic [IAFU_IRQ_W-1:0] irq_st_q;
    logic [IAFU_IRQ_W-1:0] irq_msk_q;
    logic [4:0]          reg_sel_q;
    logic                sw_exc_wr;

    // Operand fetch; only registers and immediates feed the adder
    wire logic [XLEN-1:0] src_a     = general_register[first_source_reg];
    wire logic [XLEN-1:0] src_b     = general_register[second_source_reg];
    wire logic            src_a_zero = (first_source_reg == 5'd0);
    wire logic [XLEN-1:0] src_a_or0 = src_a_zero ? IAFU_ZERO[XLEN-1:0]
                                              : src_a;
    // Sign extension of the 16-bit immediate
    wire logic [XLEN-1:0] imm_sx = {{(XLEN-16){signed_immediate[15]}},
                                    signed_immediate};
    // Shifted immediate: immediate above sixteen zero bits
    wire logic [XLEN-1:0] imm_sh = {signed_immediate, 16'h0000};

    // Operand selection per addition form
    logic [XLEN-1:0] opnd_a;
    logic [XLEN-1:0] opnd_b;
    logic            cin;
    logic            upd_ca;
    logic            may_ov;
    always_comb begin
        opnd_a = src_a;
        opnd_b = src_b;
        cin    = 1'b0;
        upd_ca = 1'b0;
        may_ov = 1'b1;
        unique case (issue_op)
            IAFU_OP_ADD: begin
                upd_ca = 1'b0;
            end
            IAFU_OP_ADDC: begin
                upd_ca = 1'b1;
            end
            IAFU_OP_ADDI: begin
                opnd_a = src_a_or0;
                opnd_b = imm_sx;
                may_ov = 1'b0;
            end
            IAFU_OP_ADDIC: begin
                opnd_a = src_a_or0;
                opnd_b = imm_sx;
                upd_ca = 1'b1;
                may_ov = 1'b0;
            end
            IAFU_OP_ADDIS: begin
                opnd_a = src_a_or0;
                opnd_b = imm_sh;
                may_ov = 1'b0;
            end
            IAFU_OP_ADDE: begin
                cin    = carry_flag_q;
                upd_ca = 1'b1;
            end
            IAFU_OP_ADDME: begin
                opnd_b = IAFU_ALL_ONES[XLEN-1:0];
                cin    = carry_flag_q;
                upd_ca = 1'b1;
            end
            IAFU_OP_ADDZE: begin
                opnd_b = IAFU_ZERO[XLEN-1:0];
                cin    = carry_flag_q;
                upd_ca = 1'b1;
            end
        endcase
    end

    // One adder; the extra bit is the carry out of the top position
    wire logic [XLEN:0]   sum_ext = {1'b0, opnd_a} + {1'b0, opnd_b}
                                    + {{XLEN{1'b0}}, cin};
    wire logic [XLEN-1:0] sum     = sum_ext[XLEN-1:0];
    wire logic            carry_o = sum_ext[XLEN];
    // Signed overflow: like-signed operands, result sign differs
    wire logic            ovf     = (opnd_a[XLEN-1] == opnd_b[XLEN-1]) &&
                                    (sum[XLEN-1] != opnd_a[XLEN-1]);

    // Form-specific update enables; immediate forms skip overflow, ADDI and ADDIS skip the record
    wire logic do_ov  = may_ov && overflow_enable;
    wire logic do_rec = record_bit &&
                        (issue_op != IAFU_OP_ADDI) &&
                        (issue_op != IAFU_OP_ADDIS);
    wire logic fire   = issue_valid && issue_ready;
    wire logic so_nxt = summary_flag_q | (do_ov & ovf);

    // Condition field from the value written
    wire logic [3:0] cf_nxt = {sum[XLEN-1],
                               ~sum[XLEN-1] & (sum != '0),
                               sum == '0,
                               so_nxt};

    // Flag writers hold issue off for one cycle so the next add
    // sees the settled carry; costs a bubble but no bypass path.
    wire logic flag_wr = fire && (upd_ca || do_ov);

    // Issue state machine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= IAFU_ST_IDLE;
        end else begin
            unique case (state_q)
                IAFU_ST_IDLE: begin
                    if (flag_wr) begin
                        state_q <= IAFU_ST_WAIT;
                    end
                end
                IAFU_ST_WAIT: begin
                    state_q <= IAFU_ST_IDLE;
                end
                default: begin
                    state_q <= IAFU_ST_IDLE;
                end
            endcase
        end
    end
    // Ready is its own flop; a bubble lasts exactly one cycle
    wire logic ready_d = !flag_wr;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            issue_ready <= 1'b1;
        end else begin
            issue_ready <= ready_d;
        end
    end

    // Result write-back to the destination register
    always_ff @(posedge aclk) begin
        if (fire) begin
            general_register[dest_reg] <= sum;
        end
    end

    // Result and done pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done   <= 1'b0;
            result <= '0;
        end else begin
            done <= fire;
            if (fire) begin
                result <= sum;
            end
        end
    end

    // Exception flags; summary is only ever set here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            carry_flag_q    <= 1'b0;
            overflow_flag_q <= 1'b0;
            summary_flag_q  <= 1'b0;
        end else if (fire) begin
            if (upd_ca) begin
                carry_flag_q <= carry_o;
            end
            if (do_ov) begin
                overflow_flag_q <= ovf;
                summary_flag_q  <= so_nxt;
            end
        end else if (sw_exc_wr) begin
            // Software write stands in for move-to-special-register
            carry_flag_q    <= s_axi_wdata[IAFU_XR_CRY];
            overflow_flag_q <= s_axi_wdata[IAFU_XR_OVF];
            summary_flag_q  <= s_axi_wdata[IAFU_XR_SO];
        end
    end

    // Condition field zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            condition_field_zero_q <= IAFU_CF_RESET;
        end else if (fire && do_rec) begin
            condition_field_zero_q <= cf_nxt;
        end
    end

    // AXI4-Lite write: take address and data together, then respond
    // Awready blocks a second take while the response is still to come
    wire logic wr_go     = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
                           !s_axi_awready;
    assign sw_exc_wr     = wr_go && (s_axi_awaddr == IAFU_A_EXC) &&
                           s_axi_wstrb[3] && !fire;
    wire logic wr_hit    = (s_axi_awaddr == IAFU_A_EXC) ||
                           (s_axi_awaddr == IAFU_A_IRQ_MSK) ||
                           (s_axi_awaddr == IAFU_A_REG_SEL);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= IAFU_RESP_OKAY;
            irq_msk_q     <= '0;
            reg_sel_q     <= '0;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // Response only after both address and data were taken
            if (s_axi_awready) begin
                s_axi_bvalid <= 1'b1;
            end
            // Busy issue cycle defers a flag register write: one writer
            if (wr_go && !(fire && s_axi_awaddr == IAFU_A_EXC)) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
                s_axi_bresp   <= wr_hit ? IAFU_RESP_OKAY : IAFU_RESP_SLVERR;
                if (s_axi_awaddr == IAFU_A_IRQ_MSK && s_axi_wstrb[0]) begin
                    irq_msk_q <= s_axi_wdata[IAFU_IRQ_W-1:0];
                end
                if (s_axi_awaddr == IAFU_A_REG_SEL && s_axi_wstrb[0]) begin
                    reg_sel_q <= s_axi_wdata[4:0];
                end
            end
        end
    end

    // Read decode
    wire logic rd_go = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
    logic [31:0] rd_data;
    logic        rd_hit;
    always_comb begin
        rd_data = '0;
        rd_hit  = 1'b1;
        unique case (s_axi_araddr)
            IAFU_A_CTRL:    rd_data = {30'd0, state_q == IAFU_ST_WAIT,
                                       issue_ready};
            IAFU_A_EXC:     rd_data = {summary_flag_q, overflow_flag_q,
                                       carry_flag_q, 29'd0};
            IAFU_A_COND:    rd_data = {28'd0, condition_field_zero_q};
            IAFU_A_IRQ_ST:  rd_data = {29'd0, irq_st_q};
            IAFU_A_IRQ_MSK: rd_data = {29'd0, irq_msk_q};
            IAFU_A_REG_SEL: rd_data = {27'd0, reg_sel_q};
            IAFU_A_REG_DAT: rd_data = general_register[reg_sel_q];
            default:        rd_hit  = 1'b0;
        endcase
    end
    wire logic st_rd = rd_go && (s_axi_araddr == IAFU_A_IRQ_ST);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= IAFU_RESP_OKAY;
        end else begin
            s_axi_arready <= rd_go;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            // Data wait in rdata until the address has been taken
            if (s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
            end
            if (rd_go) begin
                s_axi_rdata  <= rd_data;
                s_axi_rresp  <= rd_hit ? IAFU_RESP_OKAY : IAFU_RESP_SLVERR;
            end
        end
    end

    // Sticky event bits; a new event wins over the clear-on-read
    wire logic [IAFU_IRQ_W-1:0] ev;
    assign ev[IAFU_IRQ_OVF] = fire && do_ov && ovf;
    assign ev[IAFU_IRQ_CRY] = fire && upd_ca && carry_o;
    assign ev[IAFU_IRQ_SO] = fire && do_ov && ovf && !summary_flag_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_st_q <= '0;
            irq <= 1'b0;
        end else begin
            irq_st_q <= (st_rd ? '0 : irq_st_q) | ev;
            irq      <= |(((st_rd ? '0 : irq_st_q) | ev) & irq_msk_q);
        end
    end

endmodule

// File: test/iafu_asserts.sv
// Checker of issue timing and zero-based sums of the add unit
`timescale 1ns/1ps
module iafu_asserts
    import iafu_pkg::*;
#(
    parameter int unsigned XLEN = IAFU_XLEN
) (
    input wire logic            aclk,
    input wire logic            aresetn,
    input wire logic            issue_valid,
    input wire iafu_op_t        issue_op,
    input wire logic [4:0]      first_source_reg,
    input wire logic [15:0]     signed_immediate,
    input wire logic            overflow_enable,
    input wire logic            issue_ready,
    input wire logic            done,
    input wire logic [XLEN-1:0] result,
    input wire logic            s_axi_awready,
    input wire logic            s_axi_wready,
    input wire logic            s_axi_bvalid,
    input wire logic            s_axi_arready,
    input wire logic            s_axi_rvalid
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Taken add, flag writer, and forms reading zero for field zero
    wire        tk = issue_valid && issue_ready;
    wire        fl = tk && (!(issue_op inside {IAFU_OP_ADD, IAFU_OP_ADDI,
        IAFU_OP_ADDIS}) || overflow_enable && issue_op == IAFU_OP_ADD);
    wire        z  = tk && first_source_reg == 5'h0;
    wire [31:0] sx = {{16{signed_immediate[15]}}, signed_immediate};

    a_done_pulse: assert property (tk |=> done)
        else $error("done missing after a taken add");
    a_done_cause: assert property (!tk |=> !done)
        else $error("done without a taken add");
    a_flag_stall: assert property (fl |=> !issue_ready)
        else $error("no bubble after a flag writer");
    a_one_bubble: assert property (!issue_ready |=> issue_ready)
        else $error("stall longer than one cycle");
    a_plain_flow: assert property (tk && !fl |=> issue_ready)
        else $error("stall after a plain add");
    a_result_hold: assert property (!done |-> $stable(result))
        else $error("result moved without done");
    a_addi_zero: assert property (z &&
        issue_op inside {IAFU_OP_ADDI, IAFU_OP_ADDIC} |=> result == $past(sx))
        else $error("immediate sum from zero wrong");
    a_addis_zero: assert property (z && issue_op == IAFU_OP_ADDIS
        |=> result == {$past(signed_immediate), 16'h0000})
        else $error("shifted sum from zero wrong");
    a_write_answer: assert property (s_axi_awready |->
        s_axi_wready ##1 s_axi_bvalid)
        else $error("write handshake split");
    a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");
    c_flag: cover property (fl);
    c_b2b: cover property (tk ##1 tk);
    c_read: cover property (s_axi_rvalid);
endmodule

bind iafu_top iafu_asserts #(.XLEN(XLEN)) iafu_asserts_i (.aclk, .aresetn,
    .issue_valid, .issue_op, .first_source_reg, .signed_immediate,
    .overflow_enable, .issue_ready, .done, .result, .s_axi_awready,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid);

// File: test/iafu_issuer.sv
// Issue-side model: holds each add until the unit takes it
`timescale 1ns/1ps
module iafu_issuer
    import iafu_pkg::*;
(
    input  wire logic   aclk,
    input  wire logic   issue_ready,
    output logic        issue_valid,
    output iafu_op_t    issue_op,
    output logic [4:0]  dest_reg,
    output logic [4:0]  first_source_reg,
    output logic [4:0]  second_source_reg,
    output logic [15:0] signed_immediate,
    output logic        overflow_enable,
    output logic        record_bit
);
    // Idle at time zero
    initial begin
        issue_valid = 1'b0;
        issue_op = IAFU_OP_ADD;
        {dest_reg, first_source_reg, second_source_reg} = 15'h0000;
        {signed_immediate, overflow_enable, record_bit} = 18'h0_0000;
    end
    // Present one add; valid stays up so the next can follow at once
    task automatic send(input iafu_op_t op, input logic [4:0] rd, s1, s2,
                        input logic [15:0] im, input logic oe, rk,
                        output logic ok);
        issue_valid <= 1'b1;
        issue_op <= op;
        dest_reg <= rd;
        first_source_reg <= s1;
        second_source_reg <= s2;
        signed_immediate <= im;
        overflow_enable <= oe;
        record_bit <= rk;
        ok = 1'b0;
        for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge aclk);
            ok = issue_ready === 1'b1;
        end
    endtask
    // Release; fields turn over so a stale value cannot pass for a new one
    task automatic stop();
        issue_valid <= 1'b0;
        issue_op <= iafu_op_t'(~issue_op);
        first_source_reg <= ~first_source_reg;
        signed_immediate <= ~signed_immediate;
    endtask
endmodule

// File: test/iafu_top_test.sv
// Random and corner-case bench for the add unit
`timescale 1ns/1ps
module iafu_top_test
    import iafu_pkg::*;
;
    logic        aclk, aresetn, issue_valid, issue_ready, done, irq;
    iafu_op_t    issue_op;
    logic [4:0]  dest_reg, first_source_reg, second_source_reg;
    logic [15:0] signed_immediate;
    logic        overflow_enable, record_bit;
    logic [31:0] result, s_axi_wdata, s_axi_rdata, rdat;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, cy, vf, so, ok;
    logic [3:0]  cf;
    logic [31:0] regs [32];
    logic [31:0] expq [$];
    int          mismatches, num_checks;

    iafu_top iafu_top_i (.aclk, .aresetn, .issue_valid, .issue_op, .dest_reg,
        .first_source_reg, .second_source_reg, .signed_immediate,
        .overflow_enable, .record_bit, .issue_ready, .done, .result, .irq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    iafu_issuer iafu_issuer_i (.aclk, .issue_ready, .issue_valid, .issue_op,
        .dest_reg, .first_source_reg, .second_source_reg, .signed_immediate,
        .overflow_enable, .record_bit);

    task automatic summarize();
        if (mismatches == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t saw %h, expected %h", $time, got, exp);
        end
    endtask
    // Bus cycles; each channel drops when its handshake is seen
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic [2:0] p;
        @(posedge aclk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        p = 3'b111;
        for (int i = 0; i < 40 && p !== 3'b000; i++) begin
            {s_axi_bready, s_axi_wvalid, s_axi_awvalid} <= p;
            @(posedge aclk);
            if (p[2] && s_axi_bvalid) resp = s_axi_bresp;
            p = p & ~{s_axi_bvalid, s_axi_wready, s_axi_awready};
        end
        {s_axi_bready, s_axi_wvalid, s_axi_awvalid} <= p;
        if (p !== 3'b000) begin
            mismatches++;
            summarize();
        end
    endtask
    task automatic rd(input logic [7:0] ad);
        logic [1:0] p;
        @(posedge aclk);
        s_axi_araddr <= ad;
        p = 2'b11;
        for (int i = 0; i < 40 && p !== 2'b00; i++) begin
            {s_axi_rready, s_axi_arvalid} <= p;
            @(posedge aclk);
            if (p[1] && s_axi_rvalid) {rdat, resp} = {s_axi_rdata, s_axi_rresp};
            p = p & ~{s_axi_rvalid, s_axi_arready};
        end
        {s_axi_rready, s_axi_arvalid} <= p;
        if (p !== 2'b00) begin
            mismatches++;
            summarize();
        end
    endtask
    // Work out the sum and flags, queue the result, then issue the add
    task automatic run(input iafu_op_t op, input logic [4:0] rd, s1, s2,
                       input logic [15:0] im, input logic oe, rk);
        logic [31:0] a, b;
        logic [32:0] s;
        a = regs[s1];
        if (s1 == 0 && op inside {[IAFU_OP_ADDI:IAFU_OP_ADDIS]})
            a = 32'h0000_0000;
        case (op)
            IAFU_OP_ADDI, IAFU_OP_ADDIC: b = {{16{im[15]}}, im};
            IAFU_OP_ADDIS: b = {im, 16'h0000};
            IAFU_OP_ADDME: b = 32'hFFFF_FFFF;
            IAFU_OP_ADDZE: b = 32'h0000_0000;
            default: b = regs[s2];
        endcase
        s = {1'b0, a} + b + (op inside {[IAFU_OP_ADDE:IAFU_OP_ADDZE]} && cy);
        if (!(op inside {IAFU_OP_ADD, IAFU_OP_ADDI, IAFU_OP_ADDIS}))
            cy = s[32];
        if (oe && !(op inside {[IAFU_OP_ADDI:IAFU_OP_ADDIS]})) begin
            vf = a[31] == b[31] && s[31] != a[31];
            so = so | vf;
        end
        if (rk && !(op inside {IAFU_OP_ADDI, IAFU_OP_ADDIS}))
            cf = {s[31], !s[31] && s[31:0] != 0, s[31:0] == 0, so};
        regs[rd] = s[31:0];
        expq.push_back(s[31:0]);
        iafu_issuer_i.send(op, rd, s1, s2, im, oe, rk, ok);
        if (!ok) begin
            mismatches++;
            summarize();
        end
    endtask
    // Stop issuing, let the last add land, then compare flags and a register
    task automatic look(input logic [4:0] r);
        iafu_issuer_i.stop();
        repeat (2) @(posedge aclk);
        rd(IAFU_A_EXC);
        chk({29'h0, rdat[31:29]}, {29'h0, so, vf, cy});
        rd(IAFU_A_COND);
        chk({28'h0, rdat[3:0]}, {28'h0, cf});
        wr(IAFU_A_REG_SEL, {27'h0, r});
        rd(IAFU_A_REG_DAT);
        chk(rdat, regs[r]);
    endtask

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // Every done pulse carries the next queued sum
    always @(posedge aclk) begin
        if (done === 1'b1) chk(result, expq.pop_front());
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, cy, vf, so, cf} = 9'h000;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {mismatches, num_checks} = 64'h0;
        s_axi_wstrb = 4'hF;
        void'($urandom(32'hd568));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset state and an unmapped place
        rd(IAFU_A_EXC);
        chk(rdat, 32'h0000_0000);
        rd(IAFU_A_IRQ_MSK);
        chk(rdat, 32'h0000_0000);
        rd(8'h1C);
        chk({28'h0, resp, rdat[1:0]}, {28'h0, IAFU_RESP_SLVERR, 2'b00});
        wr(8'h1C, 32'h0000_0001);
        chk({30'h0, resp}, {30'h0, IAFU_RESP_SLVERR});
        // Fill registers back to back; flag bits must be ignored here
        for (int r = 0; r < 32; r++) begin
            run(IAFU_OP_ADDIS, 5'(r), 5'h0, 5'h0, 16'($urandom), 1'b1, 1'b1);
            run(IAFU_OP_ADDI, 5'(r), 5'(r), 5'h0, 16'($urandom), 1'b1, 1'b1);
        end
        look(5'h0);
        chk({31'h0, irq}, 32'h0000_0000);
        // Overflow raises an unmasked event; summary stays set afterwards
        wr(IAFU_A_EXC, 32'h0000_0000);
        {cy, vf, so} = 3'b000;
        rd(IAFU_A_IRQ_ST);
        wr(IAFU_A_IRQ_MSK, 32'h0000_0007);
        run(IAFU_OP_ADDIS, 5'h1, 5'h0, 5'h0, 16'h8000, 1'b0, 1'b0);
        run(IAFU_OP_ADDI, 5'h1, 5'h1, 5'h0, 16'hFFFF, 1'b0, 1'b0);
        run(IAFU_OP_ADDI, 5'h2, 5'h0, 5'h0, 16'h0001, 1'b0, 1'b0);
        run(IAFU_OP_ADD, 5'h3, 5'h1, 5'h2, 16'h0000, 1'b1, 1'b1);
        look(5'h3);
        chk({31'h0, irq}, 32'h0000_0001);
        rd(IAFU_A_IRQ_ST);
        chk(rdat, 32'h0000_0005);
        run(IAFU_OP_ADD, 5'h4, 5'h2, 5'h2, 16'h0000, 1'b1, 1'b1);
        look(5'h4);
        chk({31'h0, irq}, 32'h0000_0000);
        // Wide sum: low words carry into the high-word extended sum
        run(IAFU_OP_ADDI, 5'h5, 5'h0, 5'h0, 16'hFFFF, 1'b0, 1'b0);
        run(IAFU_OP_ADDC, 5'h6, 5'h5, 5'h2, 16'h0000, 1'b0, 1'b0);
        run(IAFU_OP_ADDE, 5'h7, 5'h2, 5'h2, 16'h0000, 1'b0, 1'b0);
        run(IAFU_OP_ADDIC, 5'h8, 5'h0, 5'h0, 16'h8000, 1'b0, 1'b1);
        look(5'h7);
        chk(rdat, 32'h0000_0003);
        // Every form in turn with random operands and encoding bits
        wr(IAFU_A_IRQ_MSK, 32'h0000_0000);
        for (int i = 0; i < 400; i++) begin
            run(iafu_op_t'(i[2:0]), 5'($urandom), 5'($urandom), 5'($urandom),
                16'($urandom), 1'($urandom), 1'($urandom));
            if (i % 5 == 4) look(5'($urandom));
        end
        look(5'h1F);
        chk({31'h0, irq}, 32'h0000_0000);
        chk(32'(expq.size()), 32'h0000_0000);
        summarize();
    end
endmodule
